/* bih_map.vh */
// register map and timing constants of the bridge interrupt handler
`ifndef BIH_MAP_VH
`define BIH_MAP_VH

// register byte addresses on the host register port
`define BIH_ADDR_RX_PENDING     16'h8000
`define BIH_ADDR_RX_LABEL_BASE  16'h8001
`define BIH_ADDR_RX_LABEL_LAST  16'h8008
`define BIH_ADDR_MASTER_PENDING 16'h800a
`define BIH_ADDR_CAN_CAPTURE    16'h800b
`define BIH_ADDR_RX_MASK        16'h8020
`define BIH_ADDR_MASTER_ENABLE  16'h8034
`define BIH_ADDR_TX_READY_EN    16'h8035

// reset values
`define BIH_RST_RX_PENDING      8'h00
`define BIH_RST_RX_LABEL        8'h00
`define BIH_RST_RX_MASK         8'h00
`define BIH_RST_CAN_CAPTURE     8'h00
`define BIH_RST_ENABLE_LOW      4'h0
`define BIH_RST_TX_READY_EN     4'h0
`define BIH_FAULT_ENABLE_ONES   4'hf

// field positions in the master pending and enable registers
`define BIH_BIT_CAN_TX_READY    0
`define BIH_BIT_CAN_FRAME_RX    1
`define BIH_BIT_SERIAL_TX_READY 2
`define BIH_BIT_FIFO_FLAG       3
`define BIH_BIT_RAM_SELFTEST    4
`define BIH_BIT_AUTOINIT_CHKSUM 5
`define BIH_BIT_AUTOINIT_VERIFY 6
`define BIH_BIT_EEPROM_PROGRAM  7

// receive interrupt pulse width when the acknowledge is held high
`define BIH_CLK_PERIOD_NS       100
`define BIH_RX_PULSE_NS         1000
`define BIH_RX_PULSE_CYC        (`BIH_RX_PULSE_NS / `BIH_CLK_PERIOD_NS)
`define BIH_RX_PULSE_CYC_W      4
// last count of the minimum pulse, sized to the counter
`define BIH_RX_PULSE_LAST       4'h9

`endif

/* bih_interrupt_handler.v */
// interrupt handler: receive channel and master interrupt logic
`timescale 1ns/100ps
`include "bih_map.vh"
//
// Functional notes
// - receive interrupt only for messages whose lookup entry flags one
// - flagged message sets channel pending bit and captures its label
// - eight read-only label captures follow the receive pending address
// - masked pending raises receive pin, held until acknowledge goes high
// - acknowledge held high gives a receive pulse of about one microsecond
// - reading receive pending returns contents, then clears it to zero
// - each receive mask bit gates its channel onto the receive pin
// - accepted CAN frame sets pending bit 1 and captures filter number
// - CAN receive drives master pin only when its enable bit is one
// - four fault bits are unmaskable, their enables read as ones
// - fault bit 7 set on eeprom programming verify mismatch
// - fault bit 6 set on auto-initialization readback mismatch
// - fault bit 5 set on auto-initialization checksum failure
// - fault bit 4 set on RAM self-test failure
// - pending bit 3 is OR of receive fifo flags, gated by enable only at the master pin
// - pending bit 2 set when an enabled serial transmitter is ready
// - pending bit 0 set when ready for next CAN transmit frame
// - master pin on enabled maskable pending bit or any fault bit
// - host uses captured filter number as relative frame pointer
// - per-transmitter enable selects which transmitters feed bit 2

module bih_interrupt_handler (
   // clock and reset
   input wire ref_clk,
   input wire resetn,
   // host register port
   input wire [15:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // serial receive message events
   input wire rx_msg_valid,
   input wire [2:0] rx_msg_chan,
   input wire [7:0] rx_msg_label,
   input wire rx_msg_irq_flag,
   // CAN receive events
   input wire can_frame_received,
   input wire [7:0] can_filter_num,
   // ready and fifo levels
   input wire [7:0] fifo_flags,
   input wire [3:0] serial_tx_ready_event,
   input wire can_tx_ready_event,
   // fault event pulses
   input wire eeprom_program_mismatch,
   input wire autoinit_verify_mismatch,
   input wire autoinit_checksum_fault,
   input wire ram_selftest_fault,
   // interrupt pins
   input wire rx_irq_ack_in,
   output reg rx_irq_out,
   output reg master_irq_out
);

   // register map seen by the host, byte addresses:
   //   8000 receive pending, one bit per channel, cleared by its read
   //   8001 to 8008 label captures of channels 0 to 7, read only
   //   800a master pending image, read only
   //   800b CAN filter capture, read only
   //   8020 receive channel mask, read and write
   //   8034 master enable, faults read as ones, low nibble writable
   //   8035 per-transmitter ready enable, low nibble writable
   // any other address reads as zero and ignores writes
   //
   // master pending image, bit by bit:
   //   7 programming verify fault, sticky until reset
   //   6 readback verify fault, sticky until reset
   //   5 checksum fault, sticky until reset
   //   4 memory self-test fault, sticky until reset
   //   3 live OR of the receive fifo flags
   //   2 live OR of the enabled transmitter ready levels
   //   1 CAN frame received, sticky until the image is read
   //   0 live CAN transmit ready level
   //
   // limitation: live bits cannot be cleared by the host; it must
   // drop their enable instead or the master pin stays asserted

   // address compare helper used throughout the decode
   function hit;
      input [15:0] a;
      input [15:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // receive channel state
   reg [7:0] rx_pending_q;
   reg [7:0] rx_pending_d;
   reg [7:0] rx_label_q [0:7];
   reg [7:0] rx_channel_mask_q;

   // CAN capture and host enables
   reg [7:0] can_filter_capture_q;
   reg [3:0] enable_low_q;
   reg [3:0] per_tx_ready_enable_q;

   // sticky fault and CAN receive bits
   reg [3:0] fault_q;
   reg [3:0] fault_d;
   reg can_rx_pend_q;
   reg can_rx_pend_d;

   // acknowledge synchroniser and receive pin timing
   reg ack_meta_q;
   reg ack_sync_q;
   reg rx_level_q;
   reg [`BIH_RX_PULSE_CYC_W-1:0] pulse_cnt_q;

   // combinational helpers
   reg [7:0] rx_set;
   reg [7:0] rdata_d;
   reg [7:0] master_pending;
   integer i;

   // read strobes that have side effects, and the masked receive level
   wire rd_rx_pending = reg_rd & hit(reg_addr, `BIH_ADDR_RX_PENDING);
   wire rd_master = reg_rd & hit(reg_addr, `BIH_ADDR_MASTER_PENDING);
   wire rx_level = |(rx_pending_q & rx_channel_mask_q);

   // decoded receive event, one hot per channel
   always @* begin
      rx_set = 8'h00;
      if (rx_msg_valid && rx_msg_irq_flag) begin
         rx_set[rx_msg_chan] = 1'b1;
      end
   end

   // receive pending: read clears, a new event in the same cycle survives
   always @* begin
      rx_pending_d = rx_pending_q;
      if (rd_rx_pending) begin
         rx_pending_d = `BIH_RST_RX_PENDING;
      end
      rx_pending_d = rx_pending_d | rx_set;
   end

   // sticky CAN receive bit, cleared by reading the master pending register
   always @* begin
      can_rx_pend_d = can_rx_pend_q;
      if (rd_master) begin
         can_rx_pend_d = 1'b0;
      end
      if (can_frame_received) begin
         can_rx_pend_d = 1'b1;
      end
   end

   // fault bits stay set until reset; the part is stuck in safe state anyway
   // fault sources may be pulses or levels: either sets the bit once,
   // and a level held across reset sets it again right after release
   always @* begin
      fault_d = fault_q;
      if (ram_selftest_fault) fault_d[0] = 1'b1;
      if (autoinit_checksum_fault) fault_d[1] = 1'b1;
      if (autoinit_verify_mismatch) fault_d[2] = 1'b1;
      if (eeprom_program_mismatch) fault_d[3] = 1'b1;
   end

   // master pending image; bits 3, 2 and 0 follow their sources live
   always @* begin
      master_pending = 8'h00;
      master_pending[`BIH_BIT_EEPROM_PROGRAM] = fault_q[3];
      master_pending[`BIH_BIT_AUTOINIT_VERIFY] = fault_q[2];
      master_pending[`BIH_BIT_AUTOINIT_CHKSUM] = fault_q[1];
      master_pending[`BIH_BIT_RAM_SELFTEST] = fault_q[0];
      master_pending[`BIH_BIT_FIFO_FLAG] = |fifo_flags;
      master_pending[`BIH_BIT_SERIAL_TX_READY] =
         |(serial_tx_ready_event & per_tx_ready_enable_q);
      master_pending[`BIH_BIT_CAN_FRAME_RX] = can_rx_pend_q;
      master_pending[`BIH_BIT_CAN_TX_READY] = can_tx_ready_event;
   end

   // read mux; unmapped addresses read as zero
   // the gap between 8008 and 800a is unmapped on purpose, so 8009
   // falls through to zero like any other hole
   always @* begin
      rdata_d = 8'h00;
      if (hit(reg_addr, `BIH_ADDR_RX_PENDING)) begin
         rdata_d = rx_pending_q;
      end else if (reg_addr >= `BIH_ADDR_RX_LABEL_BASE &&
                   reg_addr <= `BIH_ADDR_RX_LABEL_LAST) begin
         rdata_d = rx_label_q[reg_addr[2:0] - 3'h1];
      end else if (hit(reg_addr, `BIH_ADDR_MASTER_PENDING)) begin
         rdata_d = master_pending;
      end else if (hit(reg_addr, `BIH_ADDR_CAN_CAPTURE)) begin
         rdata_d = can_filter_capture_q;
      end else if (hit(reg_addr, `BIH_ADDR_RX_MASK)) begin
         rdata_d = rx_channel_mask_q;
      end else if (hit(reg_addr, `BIH_ADDR_MASTER_ENABLE)) begin
         rdata_d = {`BIH_FAULT_ENABLE_ONES, enable_low_q};
      end else if (hit(reg_addr, `BIH_ADDR_TX_READY_EN)) begin
         rdata_d = {4'h0, per_tx_ready_enable_q};
      end
   end

   // pending, fault and CAN receive state
   // reset defaults
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rx_pending_q <= `BIH_RST_RX_PENDING;
         fault_q <= 4'h0;
         can_rx_pend_q <= 1'b0;
      end else begin
         rx_pending_q <= rx_pending_d;
         fault_q <= fault_d;
         can_rx_pend_q <= can_rx_pend_d;
      end
   end

   // read data holds until the next read so a slow host can fetch it
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end
   end

   // label captures; a later message on a channel overwrites the label,
   // so a host that services late sees only the newest one
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         for (i = 0; i < 8; i = i + 1) begin
            rx_label_q[i] <= `BIH_RST_RX_LABEL;
         end
      end else begin
         if (rx_msg_valid && rx_msg_irq_flag) begin
            rx_label_q[rx_msg_chan] <= rx_msg_label;
         end
      end
   end

   // CAN filter capture, newest accepted frame wins
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         can_filter_capture_q <= `BIH_RST_CAN_CAPTURE;
      end else if (can_frame_received) begin
         can_filter_capture_q <= can_filter_num;
      end
   end

   // host writable registers; writes to read-only addresses are dropped
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rx_channel_mask_q <= `BIH_RST_RX_MASK;
         enable_low_q <= `BIH_RST_ENABLE_LOW;
         per_tx_ready_enable_q <= `BIH_RST_TX_READY_EN;
      end else if (reg_wr) begin
         if (hit(reg_addr, `BIH_ADDR_RX_MASK)) begin
            rx_channel_mask_q <= reg_wdata;
         end else if (hit(reg_addr, `BIH_ADDR_MASTER_ENABLE)) begin
            enable_low_q <= reg_wdata[3:0];
         end else if (hit(reg_addr, `BIH_ADDR_TX_READY_EN)) begin
            per_tx_ready_enable_q <= reg_wdata[3:0];
         end
      end
   end

   // acknowledge pin synchroniser
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ack_meta_q <= 1'b0;
         ack_sync_q <= 1'b0;
      end else begin
         ack_meta_q <= rx_irq_ack_in;
         ack_sync_q <= ack_meta_q;
      end
   end

   // receive pin timing, in clock cycles of 100 ns:
   //   the pin rises on the edge that takes a masked event, or one edge
   //   after a mask write uncovers an already pending channel
   //   it then stays high for at least ten cycles, about one microsecond
   //   after that it falls on the first edge that sees the synchronised
   //   acknowledge high, two edges behind the acknowledge pin
   //   with the acknowledge tied high the pin gives exactly ten cycles
   // limitation: events arriving while the pin is high do not stretch it,
   // and the host learns of them only from the pending register
   // trade-off: the synchroniser adds two cycles of acknowledge latency
   // in exchange for a safe sample of an asynchronous host pin
   //
   // receive pin: raised by a new masked event or a rising masked level;
   // the minimum width keeps a tied-high acknowledge from eating the pulse
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rx_irq_out <= 1'b0;
         rx_level_q <= 1'b0;
         pulse_cnt_q <= {`BIH_RX_PULSE_CYC_W{1'b0}};
      end else begin
         rx_level_q <= rx_level;
         if (!rx_irq_out && ((|(rx_set & rx_channel_mask_q)) ||
                             (rx_level && !rx_level_q))) begin
            rx_irq_out <= 1'b1;
            pulse_cnt_q <= {`BIH_RX_PULSE_CYC_W{1'b0}};
         end else if (rx_irq_out) begin
            if (pulse_cnt_q != `BIH_RX_PULSE_LAST) begin
               pulse_cnt_q <= pulse_cnt_q + 1'b1;
            end else if (ack_sync_q) begin
               rx_irq_out <= 1'b0;
            end
         end
      end
   end

   // master pin from the current pending image
   // one cycle behind the image, so a live source that pulses for a
   // single cycle still yields a one-cycle master pulse
   // faults bypass the enables, they can never be masked
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         master_irq_out <= 1'b0;
      end else begin
         master_irq_out <= (|(master_pending[3:0] & enable_low_q)) |
                           (|master_pending[7:4]);
      end
   end

endmodule // bih_interrupt_handler

/* bih_irq_properties.sv */
// concurrent checks on the interrupt handler ports
`timescale 1ns/100ps
module bih_irq_properties (
   // clock and reset
   input wire ref_clk,
   input wire resetn,
   // register port
   input wire [15:0] reg_addr,
   input wire reg_rd,
   input wire reg_wr,
   input wire [7:0] reg_rdata,
   // events and pins
   input wire rx_msg_valid,
   input wire rx_msg_irq_flag,
   input wire ram_selftest_fault,
   input wire rx_irq_ack_in,
   input wire rx_irq_out,
   input wire master_irq_out
);
   // one clock domain, so clock and reset are given once
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   rx_cause_a: assert property ($rose(rx_irq_out) |->
      $past(rx_msg_valid && rx_msg_irq_flag) || $past(reg_wr, 2))
      else $error("receive pin rose without a cause");
   rx_hold_a: assert property ($rose(rx_irq_out) |=>
      rx_irq_out [*8]) else $error("receive pin pulse too short");
   rx_pulse_a: assert property ($rose(rx_irq_out) && rx_irq_ack_in &&
      $past(rx_irq_ack_in, 2) |-> ##[10:11] !rx_irq_out)
      else $error("receive pulse did not end with ack held high");
   // the pin may only drop once the synchronised ack has been seen
   rx_fall_a: assert property ($fell(rx_irq_out) |->
      $past(rx_irq_ack_in, 2) || $past(rx_irq_ack_in, 3))
      else $error("receive pin fell without ack");
   rd_clear_a: assert property (reg_rd && reg_addr == 16'h8000 &&
      !rx_msg_valid ##1 reg_rd && reg_addr == 16'h8000 && !rx_msg_valid
      |=> reg_rdata == 8'h00) else $error("pending not cleared by read");
   unmap_rd_a: assert property (reg_rd && reg_addr == 16'h8010 |=>
      reg_rdata == 8'h00) else $error("unmapped read not zero");
   en_ones_a: assert property (reg_rd && reg_addr == 16'h8034 |=>
      reg_rdata[7:4] == 4'hf) else $error("fault enables not ones");
   fault_master_irq_out_a: assert property (ram_selftest_fault |->
      ##2 master_irq_out [*3]) else $error("fault did not hold master pin");
endmodule // bih_irq_properties

bind bih_interrupt_handler bih_irq_properties u_chk (.ref_clk, .resetn,
   .reg_addr, .reg_rd, .reg_wr, .reg_rdata, .rx_msg_valid,
   .rx_msg_irq_flag, .ram_selftest_fault, .rx_irq_ack_in, .rx_irq_out,
   .master_irq_out);

/* bih_host_model.sv */
// host cpu model answering the receive interrupt pin
`timescale 1ns/100ps
module bih_host_model (
   // clock and control
   input wire ref_clk,
   input wire hold_ack,
   // interrupt pins
   input wire rx_irq_out,
   output reg rx_irq_ack_in = 1'b0
);
   reg [4:0] wait_q = 5'h0;
   // slow ack
   // a slow host acks late so the pin must hold well past its minimum
   always @(posedge ref_clk) begin
      wait_q <= rx_irq_out ? wait_q + 5'h1 : 5'h0;
      rx_irq_ack_in <= hold_ack | (wait_q >= 5'd15);
   end
endmodule // bih_host_model

/* testbench.sv */
// self-checking bench for the interrupt handler
`timescale 1ns/100ps
module testbench;
   reg ref_clk = 1'b0;
   reg resetn = 1'b0;
   reg [15:0] reg_addr = 16'h0000;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg [7:0] reg_wdata = 8'h00;
   reg rx_msg_valid = 1'b0;
   reg [2:0] rx_msg_chan = 3'h0;
   reg [7:0] rx_msg_label = 8'h00;
   reg rx_msg_irq_flag = 1'b0;
   reg can_frame_received = 1'b0;
   reg [7:0] can_filter_num = 8'h00;
   reg [7:0] fifo_flags = 8'h00;
   reg [3:0] serial_tx_ready_event = 4'h0;
   reg can_tx_ready_event = 1'b0;
   reg [3:0] flt = 4'h0; // eeprom, verify, checksum, selftest
   reg hold_ack = 1'b0;
   wire [7:0] reg_rdata;
   wire rx_irq_ack_in;
   wire rx_irq_out;
   wire master_irq_out;
   integer n_errors = 0;
   integer compares = 0;
   integer i;
   bih_interrupt_handler dut (.ref_clk, .resetn, .reg_addr, .reg_wr,
      .reg_rd, .reg_wdata, .reg_rdata, .rx_msg_valid, .rx_msg_chan,
      .rx_msg_label, .rx_msg_irq_flag, .can_frame_received,
      .can_filter_num, .fifo_flags, .serial_tx_ready_event,
      .can_tx_ready_event, .eeprom_program_mismatch(flt[3]),
      .autoinit_verify_mismatch(flt[2]), .autoinit_checksum_fault(flt[1]),
      .ram_selftest_fault(flt[0]), .rx_irq_ack_in, .rx_irq_out,
      .master_irq_out);
   bih_host_model host (.ref_clk, .hold_ack, .rx_irq_out, .rx_irq_ack_in);
   // 10 mhz clock
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   task finish_test;
      begin
         $display("errors %0d compares %0d", n_errors, compares);
         if (n_errors == 0 && compares > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // every task returns just after an edge, where inputs change
   task cyc(input integer n);
      begin
         repeat (n) @(posedge ref_clk);
         #1;
      end
   endtask
   task rst;
      begin
         resetn = 1'b0;
         cyc(5);
         chk(rx_irq_out | master_irq_out, 8'h00);
         resetn = 1'b1;
      end
   endtask
   task wr(input [15:0] a, input [7:0] d);
      begin
         reg_addr = a;
         reg_wdata = d;
         reg_wr = 1'b1;
         cyc(1);
         reg_wr = 1'b0;
      end
   endtask
   task rd(input [15:0] a, input [7:0] e);
      begin
         reg_addr = a;
         reg_rd = 1'b1;
         cyc(1);
         reg_rd = 1'b0;
         chk(reg_rdata, e);
      end
   endtask
   task ev(input [2:0] c, input [7:0] l, input f);
      begin
         rx_msg_chan = c;
         rx_msg_label = l;
         rx_msg_irq_flag = f;
         rx_msg_valid = 1'b1;
         cyc(1);
         rx_msg_valid = 1'b0;
      end
   endtask
   task can_rx;
      begin
         can_filter_num = 8'ha1;
         can_frame_received = 1'b1;
         cyc(1);
         can_frame_received = 1'b0;
         cyc(1);
      end
   endtask
   // main sequence
   initial begin
      rst;
      rd(16'h8001, 8'h00);
      rd(16'h8020, 8'h00);
      rd(16'h8034, 8'hf0);
      rd(16'h8010, 8'h00);
      wr(16'h8020, 8'h80);
      ev(3'h3, 8'h11, 1'b0);
      rd(16'h8000, 8'h00);
      ev(3'h2, 8'h5a, 1'b1);
      chk(rx_irq_out, 8'h00);
      rd(16'h8003, 8'h5a);
      ev(3'h7, 8'hd4, 1'b1);
      cyc(12);
      chk(rx_irq_out, 8'h01);
      cyc(12);
      chk(rx_irq_out, 8'h00);
      rd(16'h8008, 8'hd4);
      // back-to-back reads: contents first, then zero
      reg_addr = 16'h8000;
      reg_rd = 1'b1;
      cyc(1);
      chk(reg_rdata, 8'h84);
      cyc(1);
      reg_rd = 1'b0;
      chk(reg_rdata, 8'h00);
      hold_ack = 1'b1;
      cyc(4);
      ev(3'h7, 8'h33, 1'b1);
      cyc(13);
      chk(rx_irq_out, 8'h00);
      rd(16'h8000, 8'h80);
      ev(3'h1, 8'h42, 1'b1);
      chk(rx_irq_out, 8'h00);
      wr(16'h8020, 8'h82);
      cyc(1);
      chk(rx_irq_out, 8'h01);
      rd(16'h8002, 8'h42);
      cyc(12);
      hold_ack = 1'b0;
      can_rx;
      chk(master_irq_out, 8'h00);
      wr(16'h8034, 8'h02);
      cyc(1);
      chk(master_irq_out, 8'h01);
      rd(16'h800b, 8'ha1);
      rd(16'h800a, 8'h02);
      fifo_flags = 8'h04;
      wr(16'h8034, 8'h08);
      rd(16'h800a, 8'h08);
      chk(master_irq_out, 8'h01);
      fifo_flags = 8'h00;
      serial_tx_ready_event = 4'h2;
      wr(16'h8035, 8'h01);
      rd(16'h800a, 8'h00);
      wr(16'h8035, 8'h02);
      can_tx_ready_event = 1'b1;
      rd(16'h800a, 8'h05);
      wr(16'h8034, 8'h04);
      cyc(1);
      chk(master_irq_out, 8'h01);
      can_tx_ready_event = 1'b0;
      serial_tx_ready_event = 4'h0;
      // faults are sticky, so each one gets a fresh reset
      for (i = 0; i < 4; i = i + 1) begin
         rst;
         flt = 4'h1 << i;
         cyc(1);
         flt = 4'h0;
         rd(16'h800a, 8'h10 << i);
         chk(master_irq_out, 8'h01);
      end
      finish_test;
   end
   // watchdog well beyond the roughly 120 cycles the tests need
   initial begin
      #300000;
      n_errors = n_errors + 1;
      finish_test;
   end
endmodule // testbench
